// >>> core/mtio_params.svh
// Purpose: constants for the motion task i/o expansion logic
// Assumes: 125 MHz control clock
// Notes:   timing counts derived from times in microseconds
`ifndef MTIO_PARAMS_SVH
`define MTIO_PARAMS_SVH
`define MTIO_CLK_MHZ        125
`define MTIO_START_DLY_US   2000
`define MTIO_START_DLY_CYC  ((`MTIO_START_DLY_US * `MTIO_CLK_MHZ))
`define MTIO_TASK_RST       8'h00
`define MTIO_TOGGLE_RST     1'b0
`define MTIO_MODE_TOGGLE    1'b0
`define MTIO_MODE_POSREG    1'b1
`endif

// >>> core/mtio_pkg.sv
// Purpose: types for the motion task i/o expansion logic
// Assumes: nothing
// Notes:   state of the top module is one packed struct
package mtio_pkg;
  typedef enum logic [1:0] {
    MTIO_IDLE,
    MTIO_RUN,
    MTIO_HALT
  } mtio_state_t;

  typedef struct packed {
    mtio_state_t state;
    logic [7:0]  task_num;
    logic [7:0]  active_task;
    logic        toggle;
    logic        in_chain;
    logic [2:0]  resume_sync;
    logic [2:0]  start_sync;
    logic        resume_seen;
    logic        start_seen;
    logic        start_pulse;
    logic        resume_pulse;
    logic        in_pos;
    logic        ferr_n;
    logic [5:0]  flags;
    logic [1:0]  met_prev;
    logic        shared_pin;
  } mtio_reg_t;
endpackage

// >>> core/mtio_core.sv
// Purpose: command inputs and status outputs of the motion task i/o card
// Assumes: motion engine status inputs come from logic on i_clk
// Notes:   start and restart pin inputs pass a three flop chain, last two must agree
//
// Operation
// - restart input resumes the interrupted motion task where it stopped.
// - base unit resume input also resumes, but is taken as a raw level with no filter or edge.
// - addressed start begins the task number presented on the eight inputs.
// - in-position output high when target lies within in-position window.
// - no broken wire detection on the in-position output.
// - next-in-position output inverts at each later start of a chained task.
// - first task of a chain drives next-in-position output low.
// - text command setting changes the next-in-position signalling form.
// - each position flag output high while its register condition is met, except flags zero and five in pulse form.
// - flag zero shares next-in-position terminal; flags zero, five set by text.
`timescale 1ns/1ps
`include "mtio_params.svh"
module mtio_core (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_resume_task_in,
  input  wire logic       i_base_resume_in,
  input  wire logic       i_addressed_task_start_in,
  input  wire logic [7:0] i_task_number,
  input  wire logic       i_target_in_window,
  input  wire logic       i_task_interrupted,
  input  wire logic       i_chain_active,
  input  wire logic       i_chain_task_start,
  input  wire logic       i_chain_first_task,
  input  wire logic       i_next_pos_mode,
  input  wire logic       i_flag_pulse_mode,
  input  wire logic       i_following_error,
  input  wire logic [5:0] i_posreg_met,
  output logic            o_task_start,
  output logic            o_task_resume,
  output logic [7:0]      o_task_select,
  output logic            o_target_reached_out,
  output logic            o_chain_step_toggle_out,
  output logic            o_tracking_error_n_out,
  output logic [5:0]      o_position_flag_out
);

  mtio_pkg::mtio_reg_t state_reg;
  mtio_pkg::mtio_reg_t state_next;

  // filtered level: change only counts when the last two stages agree
  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[2] == s[1]) ? s[1] : prev;
  endfunction

  // rising edge of a filtered level against the level held last cycle
  function automatic logic rise(input logic [2:0] s, input logic prev);
    rise = filt(s, prev) & ~prev;
  endfunction

  // shared terminal source, one place so mode decoding cannot drift
  function automatic logic pick(input logic mode, input logic tgl, input logic flag0);
    pick = (mode == `MTIO_MODE_TOGGLE) ? tgl : flag0;
  endfunction

  logic resume_lvl;
  logic start_lvl;
  logic resume_edge;
  logic start_edge;
  logic base_resume;
  logic resume_req;

  // base resume comes from the base unit on i_clk, no synchroniser needed
  assign base_resume = i_base_resume_in;

  // edges of the filtered pins; a level held high never starts twice
  assign resume_edge = rise(state_reg.resume_sync, state_reg.resume_seen);
  assign start_edge  = rise(state_reg.start_sync, state_reg.start_seen);
  // either resume source; only acted on while a task stands interrupted
  assign resume_req  = resume_edge | base_resume;

  always_comb begin
    state_next = state_reg;
    state_next.start_pulse  = 1'b0;
    state_next.resume_pulse = 1'b0;
    // bit 0 is taken by the second flop only, then the third
    state_next.resume_sync = {state_reg.resume_sync[1:0], i_resume_task_in};
    state_next.start_sync  = {state_reg.start_sync[1:0], i_addressed_task_start_in};
    resume_lvl = filt(state_reg.resume_sync, state_reg.resume_seen);
    start_lvl  = filt(state_reg.start_sync, state_reg.start_seen);
    state_next.resume_seen = resume_lvl;
    state_next.start_seen  = start_lvl;
    // task number bus registered every cycle, copied to the active task on the start edge
    state_next.task_num = i_task_number; // bit 0 lsb, bit 7 msb
    case (state_reg.state)
      mtio_pkg::MTIO_IDLE, mtio_pkg::MTIO_RUN: begin
        if (start_edge) begin
          state_next.active_task = state_reg.task_num;
          state_next.start_pulse = 1'b1;
          state_next.state       = mtio_pkg::MTIO_RUN;
        end else if (i_task_interrupted) begin
          state_next.state = mtio_pkg::MTIO_HALT;
        end
      end
      mtio_pkg::MTIO_HALT: begin
        // resume keeps the stored task, motion engine continues from stop point
        if (resume_req) begin
          state_next.resume_pulse = 1'b1;
          state_next.state        = mtio_pkg::MTIO_RUN;
        end else if (start_edge) begin
          state_next.active_task = state_reg.task_num;
          state_next.start_pulse = 1'b1;
          state_next.state       = mtio_pkg::MTIO_RUN;
        end
      end
      default: begin
        state_next.state = mtio_pkg::MTIO_IDLE;
      end
    endcase
    // chain toggle: first task forces low, later starts invert
    state_next.in_chain = i_chain_active;
    if (i_chain_active && i_chain_task_start) begin
      if (i_chain_first_task) begin
        state_next.toggle = 1'b0;
      end else begin
        state_next.toggle = ~state_reg.toggle;
      end
    end
    // plain level, no wire break sensing possible on this output
    state_next.in_pos = i_target_in_window;
    state_next.ferr_n = ~i_following_error;
    // flag zero and five may be pulse form, chosen by text command
    state_next.flags    = i_posreg_met;
    state_next.met_prev = {i_posreg_met[5], i_posreg_met[0]};
    if (i_flag_pulse_mode) begin
      // edge against the stored condition, so a held condition gives one pulse
      state_next.flags[0] = i_posreg_met[0] & ~state_reg.met_prev[0];
      state_next.flags[5] = i_posreg_met[5] & ~state_reg.met_prev[1];
    end
    // shared terminal registered so the pin comes straight from a flop
    state_next.shared_pin = pick(i_next_pos_mode, state_next.toggle, state_next.flags[0]);
  end

  // single register stage for all state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= '0;
      state_reg.state  <= mtio_pkg::MTIO_IDLE;
      state_reg.ferr_n <= 1'b1;
      state_reg.toggle <= `MTIO_TOGGLE_RST;
      state_reg.active_task <= `MTIO_TASK_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flops
  assign o_task_start         = state_reg.start_pulse;
  assign o_task_resume        = state_reg.resume_pulse;
  assign o_task_select        = state_reg.active_task;
  assign o_target_reached_out = state_reg.in_pos;
  // shared terminal, picked one cycle earlier so it leaves a flop
  assign o_chain_step_toggle_out = state_reg.shared_pin;
  assign o_tracking_error_n_out = state_reg.ferr_n;
  assign o_position_flag_out    = state_reg.flags;

  // checks
  property p_ferr;
    @(posedge i_clk) disable iff (i_rst) i_following_error |=> !o_tracking_error_n_out;
  endproperty
  a_ferr: assert property (p_ferr) else $error("ferr not low");

  property p_target_reached_out;
    @(posedge i_clk) disable iff (i_rst)
      i_target_in_window |=> o_target_reached_out;
  endproperty
  a_target_reached_out: assert property (p_target_reached_out) else $error("target_reached_out not high");

  property p_first;
    @(posedge i_clk) disable iff (i_rst)
      (i_chain_active && i_chain_task_start && i_chain_first_task) |=> !state_reg.toggle;
  endproperty
  a_first: assert property (p_first) else $error("first chain task not low");

  property p_toggle;
    @(posedge i_clk) disable iff (i_rst)
      (i_chain_active && i_chain_task_start && !i_chain_first_task)
      |=> state_reg.toggle != $past(state_reg.toggle);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed");

  property p_start;
    @(posedge i_clk) disable iff (i_rst)
      $rose(state_reg.start_sync[2]) && state_reg.start_sync[1] && !state_reg.start_seen &&
      !(state_reg.state == mtio_pkg::MTIO_HALT && resume_req)
      |=> o_task_start ##0 o_task_select == $past(state_reg.task_num);
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_resume;
    @(posedge i_clk) disable iff (i_rst)
      (state_reg.state == mtio_pkg::MTIO_HALT && base_resume) |=> o_task_resume;
  endproperty
  a_resume: assert property (p_resume) else $error("base resume lost");

  property p_keep;
    @(posedge i_clk) disable iff (i_rst)
      o_task_resume |-> $stable(o_task_select);
  endproperty
  a_keep: assert property (p_keep) else $error("resume changed task");

  property p_flag;
    @(posedge i_clk) disable iff (i_rst)
      (i_posreg_met[3] && !i_flag_pulse_mode) |=> o_position_flag_out[3];
  endproperty
  a_flag: assert property (p_flag) else $error("flag not high");

  // shared terminal equals the selected source flop one cycle after the mode is set
  property p_mux;
    @(posedge i_clk) disable iff (i_rst)
      i_next_pos_mode == `MTIO_MODE_POSREG |=> o_chain_step_toggle_out == state_reg.flags[0];
  endproperty
  a_mux: assert property (p_mux) else $error("shared terminal wrong");

  property p_tmode;
    @(posedge i_clk) disable iff (i_rst)
      i_next_pos_mode == `MTIO_MODE_TOGGLE |=> o_chain_step_toggle_out == state_reg.toggle;
  endproperty
  a_tmode: assert property (p_tmode) else $error("toggle not on terminal");

  // level outputs also drop back, not only rise
  property p_ferr_off;
    @(posedge i_clk) disable iff (i_rst)
      !i_following_error |=> o_tracking_error_n_out;
  endproperty
  a_ferr_off: assert property (p_ferr_off) else $error("ferr not released");

  property p_target_reached_out_off;
    @(posedge i_clk) disable iff (i_rst)
      !i_target_in_window |=> !o_target_reached_out;
  endproperty
  a_target_reached_out_off: assert property (p_target_reached_out_off) else $error("target_reached_out stuck high");

  // middle flags are always plain levels
  property p_flag_lvl;
    @(posedge i_clk) disable iff (i_rst)
      1'b1 |=> o_position_flag_out[4:1] == $past(i_posreg_met[4:1]);
  endproperty
  a_flag_lvl: assert property (p_flag_lvl) else $error("middle flags wrong");

  // pulse form: a flag high in pulse mode must drop again the next cycle
  property p_pulse0;
    @(posedge i_clk) disable iff (i_rst)
      i_flag_pulse_mode && o_position_flag_out[0] |=> !o_position_flag_out[0];
  endproperty
  a_pulse0: assert property (p_pulse0) else $error("flag zero pulse too long");

  property p_pulse5;
    @(posedge i_clk) disable iff (i_rst)
      i_flag_pulse_mode && o_position_flag_out[5] |=> !o_position_flag_out[5];
  endproperty
  a_pulse5: assert property (p_pulse5) else $error("flag five pulse too long");

  // resume only from an interrupted task, and it leaves the task running
  property p_refuse;
    @(posedge i_clk) disable iff (i_rst)
      state_reg.state != mtio_pkg::MTIO_HALT |=> !o_task_resume;
  endproperty
  a_refuse: assert property (p_refuse) else $error("resume while not halted");

  property p_run;
    @(posedge i_clk) disable iff (i_rst)
      o_task_resume |-> state_reg.state == mtio_pkg::MTIO_RUN;
  endproperty
  a_run: assert property (p_run) else $error("resume did not run");

  property p_halt;
    @(posedge i_clk) disable iff (i_rst)
      state_reg.state == mtio_pkg::MTIO_RUN && i_task_interrupted && !start_edge
      |=> state_reg.state == mtio_pkg::MTIO_HALT;
  endproperty
  a_halt: assert property (p_halt) else $error("interrupt not held");

  // one start pulse per pin edge, and the selection moves only with it
  property p_one;
    @(posedge i_clk) disable iff (i_rst)
      o_task_start |=> !o_task_start;
  endproperty
  a_one: assert property (p_one) else $error("start pulse too long");

  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
      !o_task_start |-> $stable(o_task_select);
  endproperty
  a_hold: assert property (p_hold) else $error("select moved without start");

  property p_num;
    @(posedge i_clk) disable iff (i_rst)
      1'b1 |=> state_reg.task_num == $past(i_task_number);
  endproperty
  a_num: assert property (p_num) else $error("task number bits moved");

  // main scenarios reached by the bench
  c_start: cover property (@(posedge i_clk) o_task_start);
  c_resume: cover property (@(posedge i_clk) o_task_resume);
  c_chain: cover property (@(posedge i_clk) state_reg.in_chain && $changed(o_chain_step_toggle_out));
  c_ferr: cover property (@(posedge i_clk) !o_tracking_error_n_out);
endmodule

// >>> testbench/mtio_plc_model.sv
// Purpose: controller side model driving task number, start and restart pins
// Assumes: pins change just after rising edges of i_clk
// Notes:   a released number shows the inverse of the last value
`timescale 1ns/1ps
module mtio_plc_model (
  input  wire logic i_clk,
  output logic      o_start,
  output logic      o_resume,
  output logic [7:0] o_number
);
  // pins idle low from time zero
  initial begin
    {o_start, o_resume, o_number} = 10'h000;
  end
  // number settles before start, so the filter never sees a moving code
  task automatic start_task(input logic [7:0] num);
    @(posedge i_clk) o_number <= num;
    repeat (3) @(posedge i_clk);
    o_start <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_start  <= 1'b0;
    o_number <= ~num; // hold over, stale code must not linger
  endtask
  // restart held long enough to pass the input filter
  task automatic pulse_resume();
    @(posedge i_clk) o_resume <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_resume <= 1'b0;
  endtask
endmodule

// >>> testbench/tb.sv
// Purpose: self-checking bench for the motion task i/o logic
// Assumes: controller model drives the command pins
// Notes:   reset and status rows first, then start, resume, chain and mode cases
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic       w;
    logic       fe;
    logic [5:0] m;
    logic       tg;
    logic       fn;
  } mtio_row_t;
  logic       i_clk, i_rst, base_res, win, intr, ch_act, ch_st, ch_first, np_mode, pmode, ferr;
  logic       st_pin, res_pin, o_st, o_res, tgt, tog, fe_n;
  logic [5:0] met, flags;
  logic [7:0] num, sel;
  int         num_errors, comparisons, n_st, n_res, n_f5;
  mtio_row_t  rows [4] = '{'{1'b1, 1'b0, 6'h00, 1'b1, 1'b1}, '{1'b0, 1'b1, 6'h3F, 1'b0, 1'b0},
                           '{1'b0, 1'b0, 6'h2A, 1'b0, 1'b1}, '{1'b1, 1'b1, 6'h15, 1'b1, 1'b0}};

  mtio_core dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_resume_task_in(res_pin),
    .i_base_resume_in(base_res), .i_addressed_task_start_in(st_pin), .i_task_number(num),
    .i_target_in_window(win), .i_task_interrupted(intr), .i_chain_active(ch_act),
    .i_chain_task_start(ch_st), .i_chain_first_task(ch_first), .i_next_pos_mode(np_mode),
    .i_flag_pulse_mode(pmode), .i_following_error(ferr), .i_posreg_met(met),
    .o_task_start(o_st), .o_task_resume(o_res), .o_task_select(sel),
    .o_target_reached_out(tgt), .o_chain_step_toggle_out(tog),
    .o_tracking_error_n_out(fe_n), .o_position_flag_out(flags));
  mtio_plc_model plc_u (.i_clk(i_clk), .o_start(st_pin), .o_resume(res_pin), .o_number(num));

  // 125 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // pulse counters, so no one-cycle output slips by unseen
  always @(posedge i_clk) begin
    if (o_st === 1'b1) n_st++;
    if (o_res === 1'b1) n_res++;
    if (flags[5] === 1'b1) n_f5++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chain_step(input logic first);
    @(posedge i_clk) {ch_act, ch_st, ch_first} <= {2'h3, first};
    @(posedge i_clk) {ch_st, ch_first} <= 2'h0;
    tick(2);
  endtask
  task automatic halt_task();
    @(posedge i_clk) intr <= 1'b1;
    @(posedge i_clk) intr <= 1'b0;
    tick(2);
  endtask
  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    i_rst = 1'b1;
    {base_res, win, intr, ch_act, ch_st, ch_first, np_mode, pmode, ferr, met} = 15'h0000;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    tick(1);
    check({tgt, tog, fe_n, flags, o_st, o_res}, 16'h0100, "reset");
    foreach (rows[i]) begin
      @(posedge i_clk) {win, ferr, met} <= {rows[i].w, rows[i].fe, rows[i].m};
      tick(2);
      check({tgt, fe_n, flags}, {rows[i].tg, rows[i].fn, rows[i].m}, "status");
    end
    // back to back starts, each with its own code
    plc_u.start_task(8'hAE);
    tick(1);
    check(16'(n_st), 16'h0001, "start count");
    check(sel, 8'hAE, "select");
    plc_u.start_task(8'h51);
    tick(1);
    check(16'(n_st), 16'h0002, "start count");
    check(sel, 8'h51, "select");
    // restart while running is ignored, then taken after a halt
    plc_u.pulse_resume();
    tick(1);
    check(16'(n_res), 16'h0000, "resume refused");
    halt_task();
    plc_u.pulse_resume();
    tick(1);
    check(16'(n_res), 16'h0001, "resume pin");
    check(sel, 8'h51, "resumed task");
    halt_task();
    @(posedge i_clk) base_res <= 1'b1;
    @(posedge i_clk) base_res <= 1'b0;
    tick(2);
    check(16'(n_res), 16'h0002, "base resume");
    check(sel, 8'h51, "resumed task");
    // chain: first task forces low, later starts invert
    for (int k = 0; k < 4; k++) begin
      chain_step(~k[0]);
      check(tog, k[0], "chain toggle");
    end
    // shared terminal shows flag zero in the other mode
    @(posedge i_clk) {np_mode, met} <= {1'b1, 6'h01};
    tick(2);
    check(tog, 1'b1, "shared flag");
    @(posedge i_clk) met <= 6'h00;
    tick(2);
    check(tog, 1'b0, "shared flag");
    // pulse form of flags zero and five
    @(posedge i_clk) pmode <= 1'b1;
    tick(2);
    n_f5 = 0;
    @(posedge i_clk) met <= 6'h21;
    tick(6);
    check(16'(n_f5), 16'h0001, "flag pulse");
    check({flags[5], flags[0]}, 2'h0, "flag pulse end");
    conclude();
  end
endmodule
